// *** hw/fps_pkg.sv ***
// Shared constants and types for the flash program/erase sequencer
package fps_pkg;

  // Command codes on the 8-bit bus data
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_PROGRAM       = 8'h40;
  localparam logic [7:0] CMD_ERASE         = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;

  // Status byte field positions; every other bit reads as zero
  localparam int unsigned STATUS_READY_BIT        = 7;
  localparam int unsigned STATUS_ERASE_FAIL_BIT   = 5;
  localparam int unsigned STATUS_PROGRAM_FAIL_BIT = 4;

  // Reset values
  localparam logic       RESET_READY       = 1'b1;
  localparam logic       RESET_FAIL        = 1'b0;
  localparam logic       RESET_STATUS_MODE = 1'b0;
  localparam logic [7:0] RESET_RDATA       = 8'h00;

  // Default address map of the user flash area
  localparam int unsigned DEF_ADDR_W      = 16;
  localparam int unsigned DEF_LOW_BASE    = 16'h2400;
  localparam int unsigned DEF_LOW_LAST    = 16'h27FF;
  localparam int unsigned DEF_HIGH_BASE   = 16'h2800;
  localparam int unsigned DEF_HIGH_LAST   = 16'h2BFF;
  localparam int unsigned DEF_OTHER_BASE  = 16'hC000;
  localparam int unsigned DEF_OTHER_LAST  = 16'hFFFF;

  // Which block an address falls in
  typedef enum logic [1:0] {
    BLK_LOW   = 2'h0,
    BLK_HIGH  = 2'h1,
    BLK_OTHER = 2'h2,
    BLK_NONE  = 2'h3
  } fps_block_type;

  // Command sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE       = 5'h01,
    ST_WAIT_PROG  = 5'h02,
    ST_WAIT_ERASE = 5'h04,
    ST_BUSY_PROG  = 5'h08,
    ST_BUSY_ERASE = 5'h10
  } fps_state_type;

endpackage

// *** hw/fps_sequencer.sv ***
// Flash program/erase command sequencer with status byte and block protection
`timescale 1ns/1ps
`default_nettype none

module fps_sequencer #(
  parameter int unsigned ADDR_W     = fps_pkg::DEF_ADDR_W,
  parameter int unsigned LOW_BASE   = fps_pkg::DEF_LOW_BASE,
  parameter int unsigned LOW_LAST   = fps_pkg::DEF_LOW_LAST,
  parameter int unsigned HIGH_BASE  = fps_pkg::DEF_HIGH_BASE,
  parameter int unsigned HIGH_LAST  = fps_pkg::DEF_HIGH_LAST,
  parameter int unsigned OTHER_BASE = fps_pkg::DEF_OTHER_BASE,
  parameter int unsigned OTHER_LAST = fps_pkg::DEF_OTHER_LAST
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RESET_N,
  input  wire logic              I_BUS_WR,
  input  wire logic              I_BUS_RD,
  input  wire logic [ADDR_W-1:0] I_BUS_ADDR,
  input  wire logic [7:0]        I_BUS_WDATA,
  output logic      [7:0]        O_BUS_RDATA,
  output logic                   O_BUS_RVALID,
  input  wire logic              I_GLOBAL_REWRITE_ENABLE,
  input  wire logic              I_LOW_BLOCK_WRITE_LOCK,
  input  wire logic              I_HIGH_BLOCK_WRITE_LOCK,
  input  wire logic              I_REWRITE_MODE_ONE,
  output logic                   O_ARRAY_PROGRAM,
  output logic                   O_ARRAY_ERASE,
  output logic      [ADDR_W-1:0] O_ARRAY_ADDR,
  output logic      [7:0]        O_ARRAY_WDATA,
  input  wire logic              I_ARRAY_DONE,
  input  wire logic              I_ARRAY_FAIL,
  input  wire logic [7:0]        I_ARRAY_RDATA,
  output logic                   O_SEQUENCER_READY_FLAG,
  output logic                   O_PROGRAM_FAIL_FLAG,
  output logic                   O_ERASE_FAIL_FLAG,
  output logic                   O_STATUS_READ_MODE
);
  import fps_pkg::*;

  // Maps an address onto the block that holds it
  function automatic fps_block_type block_of(input logic [ADDR_W-1:0] addr);
    fps_block_type blk;
    blk = BLK_NONE;
    if (addr >= ADDR_W'(LOW_BASE) && addr <= ADDR_W'(LOW_LAST)) begin
      blk = BLK_LOW;
    end else if (addr >= ADDR_W'(HIGH_BASE) && addr <= ADDR_W'(HIGH_LAST)) begin
      blk = BLK_HIGH;
    end else if (addr >= ADDR_W'(OTHER_BASE) && addr <= ADDR_W'(OTHER_LAST)) begin
      blk = BLK_OTHER;
    end
    return blk;
  endfunction

  fps_state_type     state;
  fps_state_type     next_state;
  logic              ready;
  logic              next_ready;
  logic              program_fail;
  logic              next_program_fail;
  logic              erase_fail;
  logic              next_erase_fail;
  logic              status_mode;
  logic              next_status_mode;
  logic [ADDR_W-1:0] cmd_addr;
  logic              start_prog;
  logic              start_erase;
  logic              seq_error;

  // Decode of the current bus write and address
  wire fps_block_type wr_blk      = block_of(I_BUS_ADDR);
  wire fps_block_type rd_blk      = block_of(I_BUS_ADDR);
  wire logic          is_ff       = (I_BUS_WDATA == CMD_READ_ARRAY);
  wire logic          any_fail    = program_fail | erase_fail;
  wire logic          low_locked  = !I_GLOBAL_REWRITE_ENABLE | I_LOW_BLOCK_WRITE_LOCK;
  wire logic          high_locked = I_HIGH_BLOCK_WRITE_LOCK;
  wire logic          addr_same   = (I_BUS_ADDR == cmd_addr);

  // Target block refused by its lock bit, or for the low block also by the rewrite enable
  wire logic blk_locked = ((wr_blk == BLK_LOW) && low_locked) ||
                          ((wr_blk == BLK_HIGH) && high_locked);

  // Status byte: only ready and the two fail bits carry information
  wire logic [7:0] status_byte = {ready, 1'b0, erase_fail, program_fail, 4'h0};

  // Reads of user flash return status while in status-read mode
  wire logic rd_status = status_mode && (rd_blk != BLK_NONE);

  // Command sequencing. Writes during a running operation are ignored,
  // so a clear can never meet a completion in the same cycle.
  always_comb begin
    next_state        = state;
    next_ready        = ready;
    next_program_fail = program_fail;
    next_erase_fail   = erase_fail;
    next_status_mode  = status_mode;
    start_prog        = 1'b0;
    start_erase       = 1'b0;
    seq_error         = 1'b0;
    case (state)
      ST_IDLE: begin
        if (I_BUS_WR) begin
          if (is_ff) begin
            next_status_mode = 1'b0;
          end else if (I_BUS_WDATA == CMD_READ_STATUS) begin
            next_status_mode = 1'b1;
          end else if (I_BUS_WDATA == CMD_CLEAR_STATUS) begin
            next_program_fail = 1'b0;
            next_erase_fail   = 1'b0;
          end else if (I_BUS_WDATA == CMD_PROGRAM) begin
            next_state = ST_WAIT_PROG;
          end else if (I_BUS_WDATA == CMD_ERASE) begin
            next_state = ST_WAIT_ERASE;
          end else begin
            seq_error = 1'b1;
          end
        end
      end
      ST_WAIT_PROG: begin
        if (I_BUS_WR) begin
          next_state = ST_IDLE;
          if (is_ff) begin
            next_status_mode = 1'b0;
          end else if (any_fail) begin
            next_state = ST_IDLE;
          end else if (!addr_same || wr_blk == BLK_NONE || blk_locked) begin
            seq_error = 1'b1;
          end else begin
            start_prog = 1'b1;
          end
        end
      end
      ST_WAIT_ERASE: begin
        if (I_BUS_WR) begin
          next_state = ST_IDLE;
          if (is_ff) begin
            next_status_mode = 1'b0;
          end else if (I_BUS_WDATA != CMD_ERASE_CONFIRM) begin
            seq_error = 1'b1;
          end else if (any_fail) begin
            next_state = ST_IDLE;
          end else if (wr_blk == BLK_NONE || blk_locked) begin
            seq_error = 1'b1;
          end else begin
            start_erase = 1'b1;
          end
        end
      end
      ST_BUSY_PROG: begin
        if (I_ARRAY_DONE) begin
          next_state = ST_IDLE;
          next_ready = 1'b1;
          if (I_ARRAY_FAIL) begin
            next_program_fail = 1'b1;
          end
        end
      end
      ST_BUSY_ERASE: begin
        if (I_ARRAY_DONE) begin
          next_state = ST_IDLE;
          next_ready = 1'b1;
          if (I_ARRAY_FAIL) begin
            next_erase_fail = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Both fail bits together flag a malformed or refused sequence
    if (seq_error) begin
      next_program_fail = 1'b1;
      next_erase_fail   = 1'b1;
    end
    // Launch: busy at once, auto status in mode zero
    if (start_prog || start_erase) begin
      next_state = start_prog ? ST_BUSY_PROG : ST_BUSY_ERASE;
      next_ready = 1'b0;
      if (!I_REWRITE_MODE_ONE) begin
        next_status_mode = 1'b1;
      end
    end
  end

  // Sequencer state and status flags
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state        <= ST_IDLE;
      ready        <= RESET_READY;
      program_fail <= RESET_FAIL;
      erase_fail   <= RESET_FAIL;
      status_mode  <= RESET_STATUS_MODE;
    end else begin
      state        <= next_state;
      ready        <= next_ready;
      program_fail <= next_program_fail;
      erase_fail   <= next_erase_fail;
      status_mode  <= next_status_mode;
    end
  end

  // First-cycle address kept so the second cycle can be checked
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cmd_addr <= '0;
    end else if (state == ST_IDLE && I_BUS_WR) begin
      cmd_addr <= I_BUS_ADDR;
    end
  end

  // Array launch strobes; address and data held for the whole operation
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ARRAY_PROGRAM <= 1'b0;
      O_ARRAY_ERASE   <= 1'b0;
      O_ARRAY_ADDR    <= '0;
      O_ARRAY_WDATA   <= 8'h00;
    end else begin
      O_ARRAY_PROGRAM <= start_prog;
      O_ARRAY_ERASE   <= start_erase;
      if (start_prog || start_erase) begin
        O_ARRAY_ADDR  <= I_BUS_ADDR;
        O_ARRAY_WDATA <= I_BUS_WDATA;
      end
    end
  end

  // Read path, one cycle latency; array data is combinational from I_BUS_ADDR
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_BUS_RDATA  <= RESET_RDATA;
      O_BUS_RVALID <= 1'b0;
    end else begin
      O_BUS_RVALID <= I_BUS_RD;
      if (I_BUS_RD) begin
        O_BUS_RDATA <= rd_status ? status_byte : I_ARRAY_RDATA;
      end
    end
  end

  // Flag outputs mirror the status flops
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SEQUENCER_READY_FLAG <= RESET_READY;
      O_PROGRAM_FAIL_FLAG    <= RESET_FAIL;
      O_ERASE_FAIL_FLAG      <= RESET_FAIL;
      O_STATUS_READ_MODE     <= RESET_STATUS_MODE;
    end else begin
      O_SEQUENCER_READY_FLAG <= next_ready;
      O_PROGRAM_FAIL_FLAG    <= next_program_fail;
      O_ERASE_FAIL_FLAG      <= next_erase_fail;
      O_STATUS_READ_MODE     <= next_status_mode;
    end
  end

endmodule

`default_nettype wire

// *** verification/fps_seq_chk.sv ***
// Concurrent checks on the sequencer top-level ports
`timescale 1ns/1ps
`default_nettype none
module fps_seq_chk #(parameter int unsigned ADDR_W = 16) (
  input wire logic              I_CLK,
  input wire logic              I_RESET_N,
  input wire logic              I_BUS_WR,
  input wire logic              I_BUS_RD,
  input wire logic [ADDR_W-1:0] I_BUS_ADDR,
  input wire logic [7:0]        I_BUS_WDATA,
  input wire logic [7:0]        O_BUS_RDATA,
  input wire logic              I_REWRITE_MODE_ONE,
  input wire logic              O_ARRAY_PROGRAM,
  input wire logic              O_ARRAY_ERASE,
  input wire logic [ADDR_W-1:0] O_ARRAY_ADDR,
  input wire logic [7:0]        O_ARRAY_WDATA,
  input wire logic              I_ARRAY_DONE,
  input wire logic              I_ARRAY_FAIL,
  input wire logic [7:0]        I_ARRAY_RDATA,
  input wire logic              O_SEQUENCER_READY_FLAG,
  input wire logic              O_PROGRAM_FAIL_FLAG,
  input wire logic              O_ERASE_FAIL_FLAG,
  input wire logic              O_STATUS_READ_MODE
);
  import fps_pkg::*;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Decoded helpers; only the upper user area is trusted as mapped here
  wire logic       launch = O_ARRAY_PROGRAM | O_ARRAY_ERASE;
  wire logic       clean  = !O_PROGRAM_FAIL_FLAG && !O_ERASE_FAIL_FLAG;
  wire logic       busy   = !O_SEQUENCER_READY_FLAG;
  wire logic       user_c = I_BUS_ADDR >= ADDR_W'(DEF_OTHER_BASE);
  wire logic [7:0] status = {O_SEQUENCER_READY_FLAG, 1'b0, O_ERASE_FAIL_FLAG,
                             O_PROGRAM_FAIL_FLAG, 4'h0};
  busy_launch_a: assert property (launch |-> busy) else $error("launch while ready");
  busy_hold_a: assert property (busy && !I_ARRAY_DONE |=> busy)
    else $error("ready before done");
  ready_back_a: assert property (busy && I_ARRAY_DONE |=> !busy)
    else $error("ready not back");
  prog_data_a: assert property (O_ARRAY_PROGRAM |-> $past(I_BUS_WR)
    && O_ARRAY_WDATA == $past(I_BUS_WDATA)) else $error("program data wrong");
  // Program launch address must be the one written in the data cycle
  prog_addr_a: assert property (O_ARRAY_PROGRAM |-> O_ARRAY_ADDR == $past(I_BUS_ADDR))
    else $error("program address wrong");
  erase_conf_a: assert property (O_ARRAY_ERASE |-> $past(I_BUS_WDATA) == CMD_ERASE_CONFIRM)
    else $error("erase without confirm");
  fail_refuse_a: assert property (launch |-> $past(clean)) else $error("launch with fail");
  auto_status_a: assert property (launch && !I_REWRITE_MODE_ONE |-> O_STATUS_READ_MODE)
    else $error("no auto status");
  status_read_a: assert property (I_BUS_RD && O_STATUS_READ_MODE && user_c
    |=> O_BUS_RDATA == $past(status)) else $error("status byte wrong");
  array_read_a: assert property (I_BUS_RD && !O_STATUS_READ_MODE
    |=> O_BUS_RDATA == $past(I_ARRAY_RDATA)) else $error("array read wrong");
  good_done_a: assert property (busy && I_ARRAY_DONE && !I_ARRAY_FAIL |=> clean)
    else $error("fail flag on success");
  bad_done_a: assert property (busy && I_ARRAY_DONE && I_ARRAY_FAIL
    |=> O_PROGRAM_FAIL_FLAG != O_ERASE_FAIL_FLAG) else $error("wrong fail flag");
  cover property (O_ARRAY_PROGRAM);
  cover property (O_ARRAY_ERASE);
  cover property (I_ARRAY_DONE && I_ARRAY_FAIL);
endmodule
`default_nettype wire

// *** verification/fps_flash_model.sv ***
// Behavioural flash array answering launch strobes after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_program,
  input  wire logic        i_erase,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [15:0] i_rd_addr,
  input  wire logic        i_fail_next,
  input  wire logic        i_slow,
  output logic             o_done,
  output logic             o_fail,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [64];
  logic [4:0] cnt;
  logic       busy;
  // Small aliased array; a failed operation leaves contents untouched
  initial foreach (mem[i]) mem[i] = 8'hFF;
  assign o_rdata = mem[i_rd_addr[5:0]];
  always @(posedge i_clk) begin
    if (i_program && !i_fail_next) mem[i_addr[5:0]] <= i_wdata;
    if (i_erase && !i_fail_next) foreach (mem[i]) mem[i] <= 8'hFF;
  end
  // Completion pulse, prompt or slow as the bench asks
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {busy, cnt, o_done, o_fail} <= '0;
    end else begin
      {o_done, o_fail} <= 2'b00;
      if (i_program | i_erase) begin
        busy <= 1'b1;
        cnt  <= i_slow ? 5'h14 : 5'h00;
      end else if (busy && cnt == 5'h00) begin
        {busy, o_done, o_fail} <= {2'b01, i_fail_next};
      end else if (busy) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_fps_sequencer.sv ***
// Self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_fps_sequencer;
  import fps_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ge = 1, lk0 = 0, lk1 = 0, m1 = 0;
  logic fnext = 0, slow = 1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  wire logic [7:0]  rdata, ardata, awdata;
  wire logic [15:0] aaddr;
  wire logic rvalid, aprog, aerase, adone, afail, rdy, pf, ef, smode;
  int err_count = 0, total_checks = 0;
  logic [7:0]  d1 [6] = '{8'h33, CMD_ERASE, CMD_PROGRAM, CMD_ERASE, CMD_PROGRAM, CMD_ERASE};
  logic [7:0]  d2 [6] = '{8'h00, 8'h12, 8'h77, CMD_ERASE_CONFIRM, 8'h77, CMD_ERASE_CONFIRM};
  logic [15:0] ad [6] = '{16'hC000, 16'hC000, 16'h2400, 16'h2400, 16'h2800, 16'h1000};
  logic [2:0]  lk [6] = '{3'h4, 3'h4, 3'h0, 3'h6, 3'h5, 3'h4};
  always #12.5 clk = ~clk;
  fps_sequencer i_fps_sequencer (.I_CLK(clk), .I_RESET_N(rst_n), .I_BUS_WR(wr), .I_BUS_RD(rd),
    .I_BUS_ADDR(addr), .I_BUS_WDATA(wdata), .O_BUS_RDATA(rdata), .O_BUS_RVALID(rvalid),
    .I_GLOBAL_REWRITE_ENABLE(ge), .I_LOW_BLOCK_WRITE_LOCK(lk0), .I_HIGH_BLOCK_WRITE_LOCK(lk1),
    .I_REWRITE_MODE_ONE(m1), .O_ARRAY_PROGRAM(aprog), .O_ARRAY_ERASE(aerase),
    .O_ARRAY_ADDR(aaddr), .O_ARRAY_WDATA(awdata), .I_ARRAY_DONE(adone), .I_ARRAY_FAIL(afail),
    .I_ARRAY_RDATA(ardata), .O_SEQUENCER_READY_FLAG(rdy), .O_PROGRAM_FAIL_FLAG(pf),
    .O_ERASE_FAIL_FLAG(ef), .O_STATUS_READ_MODE(smode));
  fps_flash_model i_fps_flash_model (.i_clk(clk), .i_reset_n(rst_n), .i_program(aprog),
    .i_erase(aerase), .i_addr(aaddr), .i_wdata(awdata), .i_rd_addr(addr),
    .i_fail_next(fnext), .i_slow(slow), .o_done(adone), .o_fail(afail), .o_rdata(ardata));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus cycles launch at the falling edge so the rising edge sees settled inputs
  task automatic wrc(logic [15:0] a, logic [7:0] d);
    @(negedge clk); {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk); wr = 0;
  endtask
  task automatic rdc(logic [15:0] a, logic [7:0] e, string n);
    @(negedge clk); {rd, addr} = {1'b1, a};
    @(negedge clk); rd = 0;
    chk(n, rdata, e);
    chk("rvalid", {7'h0, rvalid}, 8'h01);
  endtask
  task automatic flags(logic [2:0] e, string n);
    chk(n, {5'h0, rdy, pf, ef}, {5'h0, e});
  endtask
  // Bounded wait for completion; a hang shows as a ready mismatch
  task automatic idle();
    int i = 0;
    while (rdy !== 1'b1 && i < 200) begin @(negedge clk); i++; end
    chk("ready", {7'h0, rdy}, 8'h01);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #250000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    flags(3'b100, "reset");
    wrc(16'hC001, CMD_PROGRAM); wrc(16'hC001, 8'h5A);
    flags(3'b000, "busy");
    chk("array addr lo", aaddr[7:0], 8'h01);
    chk("array addr hi", aaddr[15:8], 8'hC0);
    chk("array data", awdata, 8'h5A);
    chk("auto status", {7'h0, smode}, 8'h01);
    rdc(16'hC000, 8'h00, "status busy");
    idle(); rdc(16'hC000, 8'h80, "status done");
    wrc(16'hC000, CMD_READ_ARRAY); rdc(16'hC001, 8'h5A, "array");
    slow = 0; fnext = 1;
    wrc(16'hC002, CMD_PROGRAM); wrc(16'hC002, 8'h33); idle();
    fnext = 0; flags(3'b110, "program fail");
    rdc(16'hC000, 8'h90, "status prog fail");
    wrc(16'hC003, CMD_PROGRAM); wrc(16'hC003, 8'h11); @(negedge clk);
    flags(3'b110, "refused");
    wrc(16'hC000, CMD_CLEAR_STATUS); flags(3'b100, "clear");
    wrc(16'hC000, CMD_READ_ARRAY); rdc(16'hC003, 8'hFF, "not written");
    fnext = 1; wrc(16'h2800, CMD_ERASE); wrc(16'h2803, CMD_ERASE_CONFIRM); idle();
    fnext = 0; flags(3'b101, "erase fail");
    rdc(16'hC000, 8'hA0, "status erase fail");
    wrc(16'hC000, CMD_CLEAR_STATUS);
    // Malformed, locked and unmapped commands all flag a sequence error
    for (int i = 0; i < 6; i++) begin
      {ge, lk0, lk1} = lk[i];
      wrc(ad[i], d1[i]); wrc(ad[i], d2[i]); flags(3'b111, "seq error");
      wrc(16'hC000, CMD_CLEAR_STATUS); {ge, lk0, lk1} = 3'h4;
    end
    wrc(16'hC000, CMD_READ_STATUS); rdc(16'hC000, 8'h80, "status cmd");
    wrc(16'hC000, CMD_ERASE); wrc(16'hC000, 8'hFF); flags(3'b100, "abort");
    rdc(16'hC001, 8'h5A, "abort array");
    wrc(16'hC000, CMD_ERASE); wrc(16'hC007, CMD_ERASE_CONFIRM); idle();
    rdc(16'hC000, 8'h80, "erase ok");
    wrc(16'hC000, CMD_READ_ARRAY); rdc(16'hC001, 8'hFF, "erased");
    m1 = 1; wrc(16'hC005, CMD_PROGRAM); wrc(16'hC005, 8'h66); idle();
    chk("mode one", {7'h0, smode}, 8'h00);
    rdc(16'hC005, 8'h66, "mode one array");
    report_and_stop();
  end
endmodule
bind fps_sequencer fps_seq_chk #(.ADDR_W(ADDR_W)) i_fps_seq_chk (.I_CLK(I_CLK),
  .I_RESET_N(I_RESET_N), .O_ARRAY_ADDR(O_ARRAY_ADDR),
  .I_BUS_WR(I_BUS_WR), .I_BUS_RD(I_BUS_RD), .I_BUS_ADDR(I_BUS_ADDR),
  .I_BUS_WDATA(I_BUS_WDATA), .O_BUS_RDATA(O_BUS_RDATA), .I_REWRITE_MODE_ONE(I_REWRITE_MODE_ONE),
  .O_ARRAY_PROGRAM(O_ARRAY_PROGRAM), .O_ARRAY_ERASE(O_ARRAY_ERASE),
  .O_ARRAY_WDATA(O_ARRAY_WDATA), .I_ARRAY_DONE(I_ARRAY_DONE), .I_ARRAY_FAIL(I_ARRAY_FAIL),
  .I_ARRAY_RDATA(I_ARRAY_RDATA), .O_SEQUENCER_READY_FLAG(O_SEQUENCER_READY_FLAG),
  .O_PROGRAM_FAIL_FLAG(O_PROGRAM_FAIL_FLAG), .O_ERASE_FAIL_FLAG(O_ERASE_FAIL_FLAG),
  .O_STATUS_READ_MODE(O_STATUS_READ_MODE));
`default_nettype wire
